// [hdl/dlp_consts.svh]
// constants for the training pattern command block
// Contract
// - pattern program taken only while the write enable latch is set
// - pattern program opcode 43h, followed by one data byte
// - pattern program dropped unless select rises right after data bit eight
// - select rising after valid pattern program starts a self-timed program cycle
// - status stays readable over the link while programming runs
// - write in progress is one for the whole program cycle, then zero
// - a failed program cycle sets the program error flag
// - end of the program cycle clears the write enable latch
// - volatile pattern write rejected unless the write enable latch is set
// - volatile pattern write opcode 4Ah, followed by one data byte
// - volatile pattern write dropped unless select rises right after data bit eight
// - valid volatile pattern write updates the volatile pattern at once, no busy
// - pattern read opcode 41h shifts out the 8-bit volatile pattern
// - pattern read repeats the byte for every further eight clocks in single-line mode, every two clocks in four-line mode
// - enabled pattern drives all lines in last 4 dummy cycles of DTR reads
// - pattern output gated by the pattern output enable bit
// - all three commands accepted in single-line and four-line mode
`ifndef DLP_CONSTS_SVH
`define DLP_CONSTS_SVH
`define DLP_NV_RESET 8'h00
`define DLP_VOL_RESET 8'h00
`define DLP_ST_WIP 0
`define DLP_ST_WEL 1
`define DLP_SPI_OP_CLKS 5'h08
`define DLP_SPI_WR_CLKS 5'h10
`define DLP_QPI_OP_CLKS 5'h02
`define DLP_QPI_WR_CLKS 5'h04
`define DLP_CNT_MAX 5'h1f
`define DLP_CNT_WRAP 5'h10
`define DLP_PAT_CYCLES 5'h04
`define DLP_CLK_MHZ 250
`define DLP_PROG_TIME_US 100
`define DLP_PROG_CYCLES (`DLP_PROG_TIME_US * `DLP_CLK_MHZ)
`endif

// [hdl/dlp_pkg.sv]
// types shared by the training pattern command block
package dlp_pkg;
  typedef enum logic [7:0] {
    OP_WRITE_DISABLE = 8'h04,
    OP_READ_STATUS   = 8'h05,
    OP_WRITE_ENABLE  = 8'h06,
    OP_READ_PATTERN  = 8'h41,
    OP_PROG_NV       = 8'h43,
    OP_WRITE_VOL     = 8'h4a
  } dlp_opcode_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_PROG = 1'b1
  } dlp_state_t;
endpackage : dlp_pkg

// [hdl/dlp_pin_sync.sv]
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps

module dlp_pin_sync #(
  parameter logic IDLE = 1'b1
) (
  // clock and reset
  input  wire logic clock_in,
  input  wire logic reset_in,
  // pin and filtered level
  input  wire logic pin_in,
  output logic      stable_out
);
  logic s1;
  logic s2;
  logic s3;

  // s1 is only read by s2, never by logic
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      s1 <= IDLE;
      s2 <= IDLE;
      s3 <= IDLE;
    end
    else
    begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a change counts only once two settled stages agree
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
      stable_out <= IDLE;
    else if (s2 == s3)
      stable_out <= s2;
  end
endmodule : dlp_pin_sync

// [hdl/dlp_link_rx.sv]
// serial-clock side receiver: opcode, data byte and clock count per frame
`timescale 1ns/1ps
`include "dlp_consts.svh"

module dlp_link_rx (
  // link clock and frame
  input  wire logic       sclk_in,
  input  wire logic       ce_n_in,
  input  wire logic [3:0] io_in,
  input  wire logic       quad_mode_in,
  // captured frame
  output logic      [7:0] opcode_out,
  output logic      [7:0] data_out,
  output logic      [4:0] count_out,
  output logic            over_out
);
  logic [7:0] sr;
  logic [7:0] next_sr;
  logic [7:0] cur_sr;
  logic [4:0] cur_cnt;
  logic [4:0] op_last;
  logic [4:0] wr_last;
  logic       fresh;

  // select high only arms a restart: clearing the words at the frame's end
  // would wipe them before the system clock has taken them
  always_ff @(posedge sclk_in or posedge ce_n_in)
  begin
    if (ce_n_in)
      fresh <= 1'b1;
    else
      fresh <= 1'b0;
  end

  // four-line mode takes a nibble per clock, single-line a bit on the input line
  always_comb
  begin
    cur_sr  = fresh ? 8'h00 : sr;
    cur_cnt = fresh ? 5'h00 : count_out;
    next_sr = quad_mode_in ? {cur_sr[3:0], io_in} : {cur_sr[6:0], io_in[0]};
    op_last = quad_mode_in ? `DLP_QPI_OP_CLKS : `DLP_SPI_OP_CLKS;
    wr_last = quad_mode_in ? `DLP_QPI_WR_CLKS : `DLP_SPI_WR_CLKS;
  end

  // words hold while select is high; the first clock of a frame restarts them
  always_ff @(posedge sclk_in)
  begin
    sr <= next_sr;
    if (cur_cnt == op_last - 5'h01)
      opcode_out <= next_sr;
    else if (fresh)
      opcode_out <= 8'h00;
    if (cur_cnt == wr_last - 5'h01)
      data_out <= next_sr;
    else if (fresh)
      data_out <= 8'h00;
    // any clock past the data byte marks the frame too long
    if (cur_cnt >= wr_last)
      over_out <= 1'b1;
    else if (fresh)
      over_out <= 1'b0;
    // wrap keeps the low bits cycling for endless read-out
    if (cur_cnt == `DLP_CNT_MAX)
      count_out <= `DLP_CNT_WRAP;
    else
      count_out <= cur_cnt + 5'h01;
  end
endmodule : dlp_link_rx

// [hdl/dlp_top.sv]
// top of the training pattern command block: decode, program timer, link output
`timescale 1ns/1ps
`include "dlp_consts.svh"

module dlp_top #(
  parameter int unsigned PROG_CYCLES = `DLP_PROG_CYCLES
) (
  // system clock and reset
  input  wire logic       clock_in,
  input  wire logic       reset_in,
  // serial link
  input  wire logic       sclk_in,
  input  wire logic       ce_n_in,
  input  wire logic [3:0] io_in,
  output logic      [3:0] io_out,
  output logic      [3:0] io_oe_out,
  // link-side configuration from the read engine
  input  wire logic       quad_mode_in,
  input  wire logic       dtr_dummy_in,
  input  wire logic [4:0] dummy_left_in,
  // control
  input  wire logic       pattern_output_enable_in,
  input  wire logic       nv_verify_fail_in,
  input  wire logic       clear_error_in,
  // status
  output logic            write_in_progress_out,
  output logic            write_enable_latch_out,
  output logic            program_error_out,
  output logic      [7:0] vol_pattern_out,
  output logic      [7:0] nv_pattern_out
);

  //////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [7:0]          rx_op;
  logic [7:0]          rx_data;
  logic [4:0]          rx_cnt;
  logic                rx_over;
  logic                ce_n_stable;
  logic                ce_n_prev;
  logic                frame_end;
  logic [7:0]          f_op;
  logic [7:0]          f_data;
  logic [4:0]          f_cnt;
  logic                f_over;
  logic                f_quad;
  logic                dec;
  logic                op_ok;
  logic                wr_ok;
  logic                start_prog;
  logic                prog_done;
  logic [23:0]         timer;
  logic [7:0]          prog_data;
  dlp_pkg::dlp_state_t state;
  logic [1:0]          st_s1;
  logic [1:0]          st_s2;
  logic [7:0]          pat_s1;
  logic [7:0]          pat_s2;
  logic                pen_s1;
  logic                pen_s2;
  logic [7:0]          rd_byte;
  logic                rd_active;
  logic [4:0]          op_clks;
  logic                pat_window;
  logic [2:0]          pat_k;
  logic [3:0]          out_q;
  logic                rise_q;
  logic                ddr_q;

  //////////////////////////////////////////////////////////////////////////////
  // link receiver and select synchroniser

  dlp_link_rx u_rx (
    .sclk_in      (sclk_in),
    .ce_n_in      (ce_n_in),
    .io_in        (io_in),
    .quad_mode_in (quad_mode_in),
    .opcode_out   (rx_op),
    .data_out     (rx_data),
    .count_out    (rx_cnt),
    .over_out     (rx_over)
  );

  dlp_pin_sync #(
    .IDLE (1'b1)
  ) u_ce_sync (
    .clock_in   (clock_in),
    .reset_in   (reset_in),
    .pin_in     (ce_n_in),
    .stable_out (ce_n_stable)
  );

  //////////////////////////////////////////////////////////////////////////////
  // frame capture in the system domain

  // edge of the filtered select marks the frame's end
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
      ce_n_prev <= 1'b1;
    else
      ce_n_prev <= ce_n_stable;
  end

  assign frame_end = ce_n_stable & ~ce_n_prev;

  // the receiver is frozen once select is high, so its words are quasi-static here
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      f_op   <= 8'h00;
      f_data <= 8'h00;
      f_cnt  <= 5'h00;
      f_over <= 1'b0;
      f_quad <= 1'b0;
      dec    <= 1'b0;
    end
    else
    begin
      dec <= frame_end;
      if (frame_end)
      begin
        f_op   <= rx_op;
        f_data <= rx_data;
        f_cnt  <= rx_cnt;
        f_over <= rx_over;
        f_quad <= quad_mode_in;
      end
    end
  end

  // exact length checks: opcode-only frames and opcode-plus-byte frames
  always_comb
  begin
    op_ok = (f_cnt == (f_quad ? `DLP_QPI_OP_CLKS : `DLP_SPI_OP_CLKS));
    wr_ok = ~f_over & (f_cnt == (f_quad ? `DLP_QPI_WR_CLKS : `DLP_SPI_WR_CLKS));
  end

  // busy blocks every write command; the program needs the latch
  assign start_prog = dec & (f_op == dlp_pkg::OP_PROG_NV) & wr_ok
                    & write_enable_latch_out & (state == dlp_pkg::ST_IDLE);
  assign prog_done  = (state == dlp_pkg::ST_PROG) && (timer == 24'h000000);

  //////////////////////////////////////////////////////////////////////////////
  // self-timed program cycle

  // the timer runs on the system clock, so no host clocking is needed
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      state     <= dlp_pkg::ST_IDLE;
      timer     <= 24'h000000;
      prog_data <= `DLP_NV_RESET;
    end
    else
    begin
      unique case (state)
        dlp_pkg::ST_IDLE:
        begin
          if (start_prog)
          begin
            state     <= dlp_pkg::ST_PROG;
            timer     <= 24'(PROG_CYCLES - 1);
            prog_data <= f_data;
          end
        end
        dlp_pkg::ST_PROG:
        begin
          if (timer == 24'h000000)
            state <= dlp_pkg::ST_IDLE;
          else
            timer <= timer - 24'h000001;
        end
      endcase
    end
  end

  // busy flag spans the whole cycle
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
      write_in_progress_out <= 1'b0;
    else if (start_prog)
      write_in_progress_out <= 1'b1;
    else if (prog_done)
      write_in_progress_out <= 1'b0;
  end

  // non-volatile pattern keeps its old value if the cells fail to verify
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
      nv_pattern_out <= `DLP_NV_RESET;
    else if (prog_done && !nv_verify_fail_in)
      nv_pattern_out <= prog_data;
  end

  // sticky error: a failure in the clearing cycle still wins
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
      program_error_out <= 1'b0;
    else if (prog_done && nv_verify_fail_in)
      program_error_out <= 1'b1;
    else if (clear_error_in)
      program_error_out <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // write enable latch and volatile pattern

  always_ff @(posedge clock_in)
  begin
    if (reset_in)
      write_enable_latch_out <= 1'b0;
    else if (prog_done)
      write_enable_latch_out <= 1'b0;
    else if (dec && op_ok && state == dlp_pkg::ST_IDLE)
    begin
      if (f_op == dlp_pkg::OP_WRITE_ENABLE)
        write_enable_latch_out <= 1'b1;
      else if (f_op == dlp_pkg::OP_WRITE_DISABLE)
        write_enable_latch_out <= 1'b0;
    end
  end

  // immediate update, no busy period
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
      vol_pattern_out <= `DLP_VOL_RESET;
    else if (dec && wr_ok && f_op == dlp_pkg::OP_WRITE_VOL
             && write_enable_latch_out && state == dlp_pkg::ST_IDLE)
      vol_pattern_out <= f_data;
  end

  //////////////////////////////////////////////////////////////////////////////
  // link-side read-out

  // the pattern only changes between frames, status also when a program cycle ends; two flops settle
  // a change made between frames before the first read-out bit, which comes after the opcode
  always_ff @(posedge sclk_in or posedge ce_n_in)
  begin
    if (ce_n_in)
    begin
      st_s1  <= 2'h0;
      st_s2  <= 2'h0;
      pat_s1 <= 8'h00;
      pat_s2 <= 8'h00;
      pen_s1 <= 1'b0;
      pen_s2 <= 1'b0;
    end
    else
    begin
      st_s1  <= {write_enable_latch_out, write_in_progress_out};
      st_s2  <= st_s1;
      pat_s1 <= vol_pattern_out;
      pat_s2 <= pat_s1;
      pen_s1 <= pattern_output_enable_in;
      pen_s2 <= pen_s1;
    end
  end

  // status stays readable while programming; the pattern read uses the volatile copy
  always_comb
  begin
    op_clks    = quad_mode_in ? `DLP_QPI_OP_CLKS : `DLP_SPI_OP_CLKS;
    rd_byte    = (rx_op == dlp_pkg::OP_READ_PATTERN) ? pat_s2
               : {6'h00, st_s2[`DLP_ST_WEL], st_s2[`DLP_ST_WIP]};
    rd_active  = (rx_cnt >= op_clks) && ((rx_op == dlp_pkg::OP_READ_PATTERN)
               || (rx_op == dlp_pkg::OP_READ_STATUS));
    pat_window = pen_s2 && dtr_dummy_in && (dummy_left_in != 5'h00)
               && (dummy_left_in <= `DLP_PAT_CYCLES);
    pat_k      = 3'(`DLP_PAT_CYCLES - dummy_left_in);
  end

  // launch on the falling edge; the pattern takes both edges in DTR dummy cycles
  always_ff @(negedge sclk_in or posedge ce_n_in)
  begin
    if (ce_n_in)
    begin
      out_q     <= 4'h0;
      io_oe_out <= 4'h0;
      ddr_q     <= 1'b0;
    end
    else if (pat_window)
    begin
      out_q     <= {4{pat_s2[3'h7 - {pat_k[1:0], 1'b0}]}};
      io_oe_out <= 4'hf;
      ddr_q     <= 1'b1;
    end
    else if (rd_active && quad_mode_in)
    begin
      out_q     <= rx_cnt[0] ? rd_byte[3:0] : rd_byte[7:4];
      io_oe_out <= 4'hf;
      ddr_q     <= 1'b0;
    end
    else if (rd_active)
    begin
      out_q     <= {2'h0, rd_byte[3'h7 - rx_cnt[2:0]], 1'b0};
      io_oe_out <= 4'h2;
      ddr_q     <= 1'b0;
    end
    else
    begin
      out_q     <= 4'h0;
      io_oe_out <= 4'h0;
      ddr_q     <= 1'b0;
    end
  end

  // second pattern bit of the cycle, shown while the clock is high
  always_ff @(posedge sclk_in or posedge ce_n_in)
  begin
    if (ce_n_in)
      rise_q <= 1'b0;
    else
      rise_q <= pat_s2[3'h6 - {pat_k[1:0], 1'b0}];
  end

  // double-rate output stage; outside the pattern window the flop drives alone
  assign io_out = (ddr_q && sclk_in) ? {4{rise_q}} : out_q;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  localparam int PROG_LEN = PROG_CYCLES;

  logic [23:0] busy_len;

  // completed busy cycles of the current program; starts at zero so that
  // the cycle in which busy falls sees exactly the full count
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
      busy_len <= 24'h000000;
    else if (start_prog)
      busy_len <= 24'h000000;
    else if (write_in_progress_out)
      busy_len <= busy_len + 24'h000001;
  end

  sequence s_prog_req;
    dec && (f_op == dlp_pkg::OP_PROG_NV) && state == dlp_pkg::ST_IDLE;
  endsequence

  sequence s_vol_req;
    dec && (f_op == dlp_pkg::OP_WRITE_VOL) && state == dlp_pkg::ST_IDLE;
  endsequence

  chk_prog_needs_wel: assert property (@(posedge clock_in) disable iff (reset_in)
    s_prog_req and !write_enable_latch_out |=> !write_in_progress_out)
    else $error("program started without write enable latch");

  chk_prog_bad_len: assert property (@(posedge clock_in) disable iff (reset_in)
    s_prog_req and !wr_ok |=> !write_in_progress_out)
    else $error("program started from a frame of wrong length");

  chk_prog_start: assert property (@(posedge clock_in) disable iff (reset_in)
    s_prog_req and wr_ok && write_enable_latch_out |=> write_in_progress_out [*8])
    else $error("valid program did not start a busy cycle");

  chk_wip_length: assert property (@(posedge clock_in) disable iff (reset_in)
    $fell(write_in_progress_out) |-> busy_len == 24'(PROG_LEN))
    else $error("busy period length wrong");

  chk_prog_error: assert property (@(posedge clock_in) disable iff (reset_in)
    prog_done && nv_verify_fail_in |=> program_error_out && $stable(nv_pattern_out))
    else $error("failed program not flagged");

  chk_wel_cleared: assert property (@(posedge clock_in) disable iff (reset_in)
    $fell(write_in_progress_out) |-> !write_enable_latch_out)
    else $error("write enable latch left set after program");

  chk_vol_reject: assert property (@(posedge clock_in) disable iff (reset_in)
    s_vol_req and !write_enable_latch_out |=> $stable(vol_pattern_out))
    else $error("volatile write taken without write enable latch");

  chk_vol_update: assert property (@(posedge clock_in) disable iff (reset_in)
    s_vol_req and wr_ok && write_enable_latch_out
    |=> vol_pattern_out == $past(f_data) && !write_in_progress_out)
    else $error("volatile pattern not updated at once");

  chk_pattern_lines: assert property (@(negedge sclk_in) disable iff (ce_n_in)
    pat_window |=> io_oe_out == 4'hf)
    else $error("pattern window did not drive all lines");

endmodule : dlp_top

// [bench/dlp_host.sv]
// host controller model that frames commands on the serial link
`timescale 1ns/1ps

module dlp_host (
  // link pins driven by the host
  output logic            sclk_out,
  output logic            ce_n_out,
  output logic      [3:0] io_out,
  // device answer
  input  wire logic [3:0] io_in,
  input  wire logic [3:0] oe_in,
  // read engine view of the frame
  output logic            quad_out,
  output logic            dtr_dummy_out,
  output logic      [4:0] dummy_left_out
);
  localparam realtime HALF = 62.5;

  ////////////////////////////////////////////////////////////////////////////////
  // idle link: clock parked low outside frames, select high
  // a select edge just after time zero arms the device's link-side restart
  initial
  begin
    sclk_out = 1'b0;
    ce_n_out = 1'b0;
    io_out = 4'h0;
    quad_out = 1'b0;
    dtr_dummy_out = 1'b0;
    dummy_left_out = 5'h00;
    #1 ce_n_out = 1'b1;
  end

  // one frame: nclk command clocks, then nrd read clocks
  task automatic xfer(input logic q, input logic [15:0] word, input int nclk, input int nrd,
                      output logic [15:0] rd);
    logic [15:0] sh;
    int          i;
    sh = word;
    rd = 16'h0000;
    quad_out = q;
    ce_n_out = 1'b0;
    for (i = 0; i < nclk + nrd; i++)
    begin
      // msb first; once the command is in the host keeps driving the lines, inverted each clock
      if (i < nclk)
        io_out = q ? sh[15:12] : {3'h0, sh[15]};
      else
        io_out = ~io_out;
      sh = q ? sh << 4 : sh << 1;
      #(HALF) sclk_out = 1'b1;
      if (i >= nclk)
        rd = q ? {rd[11:0], io_in} : {rd[14:0], io_in[1]};
      #(HALF) sclk_out = 1'b0;
    end
    // select rises right after the last latched bit
    #(HALF) ce_n_out = 1'b1;
    io_out = ~io_out;
    #200;
  endtask : xfer

  // dtr read with five dummy cycles; samples the lines in each half of the last four
  task automatic dtr(output logic [31:0] seen, output logic [15:0] oe);
    int k;
    logic [7:0] op;
    op = 8'h0d;
    seen = 32'h0000_0000;
    oe = 16'h0000;
    quad_out = 1'b0;
    ce_n_out = 1'b0;
    for (k = 7; k >= 0; k--)
    begin
      io_out = {3'h0, op[k]};
      #(HALF) sclk_out = 1'b1;
      #(HALF) sclk_out = 1'b0;
    end
    #10;
    for (k = 5; k >= 0; k--)
    begin
      io_out = ~io_out;
      #(HALF - 10) sclk_out = 1'b1;
      #10;
      if (k < 4)
        seen = {seen[27:0], io_in};
      dtr_dummy_out = (k > 0);
      dummy_left_out = k[4:0];
      #(HALF - 10) sclk_out = 1'b0;
      #10;
      if (k > 0 && k < 5)
      begin
        seen = {seen[27:0], io_in};
        oe = {oe[11:0], oe_in};
      end
    end
    #(HALF - 10) ce_n_out = 1'b1;
    #200;
  endtask : dtr
endmodule : dlp_host

// [bench/dlp_tb_top.sv]
// self-checking bench for the training pattern command block
`timescale 1ns/1ps

module dlp_tb_top;
  localparam int unsigned PROG = 1000;
  typedef struct packed {
    logic        quad;
    logic [15:0] word;
    logic [4:0]  nclk;
    logic [4:0]  nrd;
    logic [15:0] rd;
    logic [7:0]  vol;
    logic [7:0]  nv;
    logic        write_enable_latch;
  } dlp_row_t;

  logic        clock_in = 1'b0;
  logic        reset_in, sclk, ce_n, quad_mode, dtr_dummy;
  logic [3:0]  link_io, dev_io, dev_oe;
  logic [4:0]  dummy_left;
  logic        pat_en, verify_fail, clear_error, write_in_progress, write_enable_latch, perr;
  logic [7:0]  vol_pat, nv_pat;
  logic [31:0] busy_cycles = 32'h00000000;
  int          fails, n_checks;
  dlp_row_t    rows [12];

  ////////////////////////////////////////////////////////////////////////////////
  dlp_top #(.PROG_CYCLES(PROG)) dut (
    .clock_in(clock_in), .reset_in(reset_in), .sclk_in(sclk), .ce_n_in(ce_n),
    .io_in(link_io), .io_out(dev_io), .io_oe_out(dev_oe), .quad_mode_in(quad_mode),
    .dtr_dummy_in(dtr_dummy), .dummy_left_in(dummy_left),
    .pattern_output_enable_in(pat_en), .nv_verify_fail_in(verify_fail),
    .clear_error_in(clear_error), .write_in_progress_out(write_in_progress),
    .write_enable_latch_out(write_enable_latch), .program_error_out(perr),
    .vol_pattern_out(vol_pat), .nv_pattern_out(nv_pat)
  );

  dlp_host host (
    .sclk_out(sclk), .ce_n_out(ce_n), .io_out(link_io), .io_in(dev_io), .oe_in(dev_oe),
    .quad_out(quad_mode), .dtr_dummy_out(dtr_dummy), .dummy_left_out(dummy_left)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // 250 MHz system clock
  always #2 clock_in = ~clock_in;

  // busy length is counted in system cycles seen high
  always @(posedge clock_in)
    if (write_in_progress === 1'b1)
      busy_cycles <= busy_cycles + 1;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test

  // enable, program, poll status mid-cycle, then wait out the busy period
  task automatic prog(input logic [7:0] d, input logic bad, input logic [7:0] exp_nv);
    logic [15:0] rd;
    logic [31:0] base;
    int          i;
    @(negedge clock_in) verify_fail = bad;
    host.xfer(1'b0, 16'h0600, 8, 0, rd);
    base = busy_cycles;
    host.xfer(1'b0, {8'h43, d}, 16, 0, rd);
    host.xfer(1'b0, 16'h0500, 8, 16, rd);
    check(rd, 16'h0303, "status while busy");
    for (i = 0; i < 3 * PROG && write_in_progress !== 1'b0; i++)
      @(negedge clock_in);
    check(busy_cycles - base, PROG, "busy length");
    check(nv_pat, exp_nv, "nv pattern");
    check(perr, bad, "program error");
    check(write_enable_latch, 1'b0, "latch after program");
    host.xfer(1'b0, 16'h0500, 8, 8, rd);
    check(rd, 16'h0000, "status after program");
  endtask : prog

  // pattern window of a dtr read, with the output enable on or off
  task automatic dtr(input logic on);
    logic [31:0] seen, exp;
    logic [15:0] oe;
    logic [7:0]  pat;
    int          i;
    @(negedge clock_in) pat_en = on;
    repeat (20) @(negedge clock_in);
    host.dtr(seen, oe);
    pat = 8'h34; // last volatile write of the table rows
    for (i = 0; i < 8; i++)
      exp[31 - 4 * i -: 4] = {4{pat[7 - i]}};
    if (on)
      check(seen, exp, "pattern on lines");
    check(oe, on ? 32'h0000_ffff : 32'h0, "pattern drive");
  endtask : dtr

  ////////////////////////////////////////////////////////////////////////////////
  // hang guard: the whole sequence needs well under this span
  initial
  begin
    #200000;
    fails++;
    $display("unexpected at %0t: watchdog expired", $time);
    end_of_test();
  end

  // main sequence: table rows first, then the hand-written cases
  initial
  begin
    logic [15:0] rd;
    reset_in = 1'b1;
    pat_en = 1'b0;
    verify_fail = 1'b0;
    clear_error = 1'b0;
    rows = '{
      '{1'b0, 16'h4355, 5'h10, 5'h00, 16'h0000, 8'h00, 8'h00, 1'b0},
      '{1'b0, 16'h4a5a, 5'h10, 5'h00, 16'h0000, 8'h00, 8'h00, 1'b0},
      '{1'b0, 16'h0600, 5'h08, 5'h00, 16'h0000, 8'h00, 8'h00, 1'b1},
      '{1'b0, 16'h4a5a, 5'h0f, 5'h00, 16'h0000, 8'h00, 8'h00, 1'b1},
      '{1'b0, 16'h4a5a, 5'h11, 5'h00, 16'h0000, 8'h00, 8'h00, 1'b1},
      '{1'b0, 16'h4355, 5'h0f, 5'h00, 16'h0000, 8'h00, 8'h00, 1'b1},
      '{1'b0, 16'h4a5a, 5'h10, 5'h00, 16'h0000, 8'h5a, 8'h00, 1'b1},
      '{1'b0, 16'h4100, 5'h08, 5'h10, 16'h5a5a, 8'h5a, 8'h00, 1'b1},
      '{1'b0, 16'h0400, 5'h08, 5'h00, 16'h0000, 8'h5a, 8'h00, 1'b0},
      '{1'b1, 16'h0600, 5'h02, 5'h00, 16'h0000, 8'h5a, 8'h00, 1'b1},
      '{1'b1, 16'h4a34, 5'h04, 5'h00, 16'h0000, 8'h34, 8'h00, 1'b1},
      '{1'b1, 16'h4100, 5'h02, 5'h04, 16'h3434, 8'h34, 8'h00, 1'b1}};
    repeat (2) @(negedge clock_in);
    reset_in = 1'b0;
    repeat (10) @(negedge clock_in);
    foreach (rows[i])
    begin
      host.xfer(rows[i].quad, rows[i].word, rows[i].nclk, rows[i].nrd, rd);
      if (rows[i].nrd != 0)
        check(rd, rows[i].rd, "read data");
      check(vol_pat, rows[i].vol, "vol pattern");
      check(nv_pat, rows[i].nv, "nv pattern");
      check(write_enable_latch, rows[i].write_enable_latch, "write latch");
      check(write_in_progress, 1'b0, "no busy");
    end
    $display("table rows done");
    prog(8'h77, 1'b0, 8'h77);
    prog(8'h88, 1'b1, 8'h77);
    @(negedge clock_in) clear_error = 1'b1;
    @(negedge clock_in) clear_error = 1'b0;
    repeat (4) @(negedge clock_in);
    check(perr, 1'b0, "error cleared");
    $display("program tests done");
    dtr(1'b1);
    dtr(1'b0);
    $display("pattern tests done");
    @(negedge clock_in) reset_in = 1'b1;
    repeat (2) @(negedge clock_in);
    reset_in = 1'b0;
    check({write_in_progress, write_enable_latch, perr, vol_pat, nv_pat}, 32'h0, "reset values");
    $display("reset test done");
    end_of_test();
  end
endmodule : dlp_tb_top
